// file: include/opmode_cfg.svh
// offsets, field positions, reset values and masks of the operating mode register bank
`ifndef OPMODE_CFG_SVH
`define OPMODE_CFG_SVH

// byte offsets on the register bus
`define OFS_SETTINGS    12'h000
`define OFS_IRQ_STATUS  12'h004
`define OFS_IRQ_MASK    12'h008
`define OFS_STATE       12'h00c

// settings register fields
`define BIT_SOFT_RESET  9
`define BIT_LATCH       7
`define BIT_PUSH_PULL   6
`define BIT_BUSY_SEL    5
`define BIT_ALARM_EN    4
`define BIT_POL_OUT0    3
`define BIT_OUT1        2
`define PD_MSB          1
`define PD_LSB          0
`define SETTINGS_RESET  16'h00c0
`define SETTINGS_WMASK  16'h00ff

// interrupt status bits
`define IRQ_ALARM_SET   0
`define IRQ_ALARM_CLR   1
`define IRQ_SOFT_RESET  2
`define IRQ_WIDTH       3

`endif

// file: include/opmode_pkg.sv
// types shared by the operating mode register bank
package opmode_pkg;
  typedef enum logic [1:0] {
    pd_all_off,
    pd_ref_only,
    pd_bias_only,
    pd_both_on
  } power_mode_type;
endpackage

// file: hdl/alarm_pin_drive.sv
// output stage of the shared alarm / busy / general output 0 pin
module alarm_pin_drive (
  // clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // function selection
  input  wire logic alarm_function_enable,
  input  wire logic busy_select,
  input  wire logic alarm_polarity_or_out0_level,
  input  wire logic push_pull,
  // internal sources
  input  wire logic alarm_state,
  input  wire logic conv_busy,
  // pin
  output logic      pin_o,
  output logic      pin_oe
);
  logic active;
  logic level;

  // busy view replaces the alarm only in alarm mode
  assign active = busy_select ? conv_busy : alarm_state;
  // polarity in alarm mode, plain level otherwise
  assign level  = alarm_function_enable ?
                  (alarm_polarity_or_out0_level ? active : ~active) :
                  alarm_polarity_or_out0_level;

  // registered so the pin never glitches on mux changes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_o  <= 1'b0;
      pin_oe <= 1'b1;
    end else begin
      pin_o  <= push_pull ? level : 1'b0;
      pin_oe <= push_pull | ~level;
    end
  end
endmodule

// file: hdl/opmode_regs.sv
// operating mode register bank with apb slave, alarm latch and interrupt
//
// Chosen here: the register offsets and register access over APB.
`include "opmode_cfg.svh"
module opmode_regs
  import opmode_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // converter events
  input  wire logic        alarm_trip,
  input  wire logic        hyst_release,
  input  wire logic        alert_read,
  input  wire logic        conv_busy,
  // soft reset actions
  output logic             soft_reset_pulse,
  output logic             trim_reload,
  // shared alarm pin and general output 1
  output logic             alarm_pin_o,
  output logic             alarm_pin_oe,
  output logic             general_out1,
  // power control
  output logic             bias_on,
  output logic             ref_on,
  // interrupt
  output logic             irq
);
  logic [15:0]            settings;
  logic                   soft_reset_trigger;
  logic                   alarm_state;
  logic [`IRQ_WIDTH-1:0]  irq_status;
  logic [`IRQ_WIDTH-1:0]  irq_mask;
  logic                   access_q;

  // address decode
  wire sel_settings = (paddr == `OFS_SETTINGS);
  wire sel_status   = (paddr == `OFS_IRQ_STATUS);
  wire sel_mask     = (paddr == `OFS_IRQ_MASK);
  wire sel_state    = (paddr == `OFS_STATE);
  wire mapped       = sel_settings | sel_status | sel_mask | sel_state;

  // one wait state: data is registered in the first access cycle
  wire access_first = psel & penable & ~access_q;
  wire wr_done      = psel & penable & access_q & pwrite;
  wire wr_settings  = wr_done & sel_settings;
  wire wr_status    = wr_done & sel_status;
  wire wr_mask      = wr_done & sel_mask;

  // byte lanes merge into the 16-bit settings
  wire [15:0] lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  wire [15:0] wr_value  = pwdata[15:0] & `SETTINGS_WMASK;
  wire [15:0] next_settings = (settings & ~(lane_mask & `SETTINGS_WMASK)) |
                              (wr_value & lane_mask);

  // named fields
  wire latch_mode            = settings[`BIT_LATCH];
  wire push_pull             = settings[`BIT_PUSH_PULL];
  wire alarm_function_enable = settings[`BIT_ALARM_EN];
  wire alarm_polarity_or_out0_level = settings[`BIT_POL_OUT0];
  // busy only acts and reads back while alarm mode is on
  wire busy_select = settings[`BIT_BUSY_SEL] & alarm_function_enable;
  wire power_mode_type pd_mode = power_mode_type'(settings[`PD_MSB:`PD_LSB]);

  // read view of settings: self-clearing trigger and masked busy
  wire [15:0] settings_view = {6'h00, soft_reset_trigger, 1'b0, settings[7:6],
                               busy_select, settings[4:0]};

  wire soft_reset_trigger_request = wr_settings & pstrb[1] & pwdata[`BIT_SOFT_RESET];

  // alarm release conditions differ by latch mode
  wire alarm_release = alert_read | (~latch_mode & hyst_release);

  wire [`IRQ_WIDTH-1:0] irq_events;
  assign irq_events[`IRQ_ALARM_SET]  = alarm_trip & ~alarm_state & ~soft_reset_trigger;
  assign irq_events[`IRQ_ALARM_CLR]  = alarm_state & ~alarm_trip &
                                       (alarm_release | soft_reset_trigger);
  assign irq_events[`IRQ_SOFT_RESET] = soft_reset_trigger;

  // settings keep their value through a soft reset; only nrst restores them
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      settings <= `SETTINGS_RESET;
    end else if (wr_settings) begin
      settings <= next_settings;
    end
  end

  // trigger lives one cycle, then reads as zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      soft_reset_trigger <= 1'b0;
    end else begin
      soft_reset_trigger <= soft_reset_trigger_request;
    end
  end

  // alarm latch; soft reset wins, then a new trip wins over a release
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      alarm_state <= 1'b0;
    end else if (soft_reset_trigger) begin
      alarm_state <= 1'b0;
    end else if (alarm_trip) begin
      alarm_state <= 1'b1;
    end else if (alarm_release) begin
      alarm_state <= 1'b0;
    end
  end

  // sticky interrupt status, write one to clear, set beats clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~(wr_status ? pwdata[`IRQ_WIDTH-1:0] : '0)) | irq_events;
    end
  end

  // interrupt mask, same layout as the status bits
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_mask <= '0;
    end else if (wr_mask) begin
      irq_mask <= pwdata[`IRQ_WIDTH-1:0];
    end
  end

  // read mux
  wire [31:0] read_value =
    sel_settings ? {16'h0000, settings_view} :
    sel_status   ? {29'h0, irq_status} :
    sel_mask     ? {29'h0, irq_mask} :
    sel_state    ? {27'h0, conv_busy, bias_on, ref_on, alarm_pin_o, alarm_state} :
                   32'h0000_0000;

  // apb answer registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      access_q <= 1'b0;
      prdata   <= '0;
      pslverr  <= 1'b0;
    end else begin
      access_q <= access_first;
      if (access_first) begin
        prdata  <= pwrite ? 32'h0000_0000 : read_value;
        pslverr <= ~mapped;
      end
    end
  end
  assign pready = access_q;

  // soft reset side effects toward result, alert and trim logic
  assign soft_reset_pulse = soft_reset_trigger;
  assign trim_reload      = soft_reset_trigger;

  // power and general output pins are registered copies of the fields
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      general_out1 <= 1'b0;
      bias_on      <= 1'b0;
      ref_on       <= 1'b0;
    end else begin
      general_out1 <= settings[`BIT_OUT1];
      bias_on      <= (pd_mode == pd_bias_only) | (pd_mode == pd_both_on);
      ref_on       <= (pd_mode == pd_ref_only) | (pd_mode == pd_both_on);
    end
  end

  // level interrupt, high while any unmasked status bit is set
  assign irq = |(irq_status & irq_mask);

  // shared pin stage
  alarm_pin_drive pin_stage (
    .clk                          (clk),
    .nrst                         (nrst),
    .alarm_function_enable        (alarm_function_enable),
    .busy_select                  (busy_select),
    .alarm_polarity_or_out0_level (alarm_polarity_or_out0_level),
    .push_pull                    (push_pull),
    .alarm_state                  (alarm_state),
    .conv_busy                    (conv_busy),
    .pin_o                        (alarm_pin_o),
    .pin_oe                       (alarm_pin_oe)
  );

  // checks
  sequence soft_reset_trigger_write_s;
    soft_reset_trigger_request;
  endsequence
  sequence soft_reset_trigger_done_s;
    soft_reset_trigger ##1 !soft_reset_trigger;
  endsequence

  a_soft_reset_trigger_self_clear: assert property (@(posedge clk) disable iff (!nrst)
    soft_reset_trigger_write_s |=> soft_reset_trigger_done_s)
    else $error("soft reset trigger did not clear after one cycle");

  a_soft_reset_trigger_clears_alarm: assert property (@(posedge clk) disable iff (!nrst)
    soft_reset_trigger |=> !alarm_state)
    else $error("alarm survived soft reset");

  a_soft_reset_trigger_keeps_cfg: assert property (@(posedge clk) disable iff (!nrst)
    (soft_reset_trigger && !wr_settings) |=> $stable(settings))
    else $error("settings changed by soft reset");

  a_trim_with_soft_reset_trigger: assert property (@(posedge clk) disable iff (!nrst)
    soft_reset_trigger_request |=> trim_reload && soft_reset_pulse)
    else $error("trim reload missing on soft reset");

  a_latch_hold: assert property (@(posedge clk) disable iff (!nrst)
    (alarm_state && latch_mode && !alert_read && !soft_reset_trigger) |=> alarm_state)
    else $error("latched alarm dropped without read");

  a_hyst_release: assert property (@(posedge clk) disable iff (!nrst)
    (alarm_state && !latch_mode && hyst_release && !alarm_trip) |=> !alarm_state)
    else $error("alarm not released past hysteresis");

  a_open_drain: assert property (@(posedge clk) disable iff (!nrst)
    !push_pull |=> (alarm_pin_o == 1'b0))
    else $error("open drain stage drove high");

  a_busy_on_pin: assert property (@(posedge clk) disable iff (!nrst)
    (busy_select && alarm_polarity_or_out0_level && push_pull &&
     alarm_function_enable) |=> alarm_pin_o == $past(conv_busy))
    else $error("pin does not show busy");

  a_busy_reads_zero: assert property (@(posedge clk) disable iff (!nrst)
    !alarm_function_enable |-> settings_view[`BIT_BUSY_SEL] == 1'b0)
    else $error("busy reads one with alarm disabled");

  a_out0_level: assert property (@(posedge clk) disable iff (!nrst)
    (!alarm_function_enable && push_pull) |=>
      alarm_pin_o == $past(alarm_polarity_or_out0_level))
    else $error("general output 0 level wrong");

  a_out1_level: assert property (@(posedge clk) disable iff (!nrst)
    1'b1 |=> general_out1 == $past(settings[`BIT_OUT1]))
    else $error("general output 1 level wrong");

  a_power_modes: assert property (@(posedge clk) disable iff (!nrst)
    1'b1 |=> {bias_on, ref_on} == $past(settings[`PD_MSB:`PD_LSB]))
    else $error("power mode outputs wrong");

  a_apb_one_wait: assert property (@(posedge clk) disable iff (!nrst)
    (psel && !penable) ##1 (psel && penable) |-> !pready ##1 pready)
    else $error("apb answer not after one wait state");
endmodule

// file: bench/conv_model.sv
// bench: converter-side event source for the operating mode register bank
module conv_model (
  // clock
  input  wire logic clk,
  // converter events
  output logic      alarm_trip,
  output logic      hyst_release,
  output logic      alert_read,
  output logic      conv_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  // all events quiet until a scenario asks for one
  initial begin
    {alarm_trip, hyst_release, alert_read, conv_busy} = 4'h0;
  end
  // one-cycle event: 0 limit crossed, 1 back past hysteresis, 2 alert read
  task pulse(input int k);
    @(posedge clk);
    {alarm_trip, hyst_release, alert_read} <= 3'h4 >> k;
    @(posedge clk);
    {alarm_trip, hyst_release, alert_read} <= 3'h0;
  endtask
  // busy is a level held for the whole conversion
  task busy(input logic v);
    @(posedge clk);
    conv_busy <= v;
  endtask
endmodule

// file: bench/tb.sv
// bench: apb-driven self-checking test of the operating mode register bank
`include "opmode_cfg.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, er, at, hr, ar, cb, srp, trl;
  logic        pin_o, pin_oe, gout1, bias_on, ref_on, irq;
  int          error_cnt = 0, samples_checked = 0, n;
  logic [7:0]  pin_set [4] = '{8'hc8, 8'hc0, 8'h88, 8'h80};
  logic [1:0]  pin_exp [4] = '{2'h3, 2'h1, 2'h0, 2'h1};
  // 125 MHz clock
  always #4 clk = ~clk;
  opmode_regs uut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .alarm_trip(at), .hyst_release(hr), .alert_read(ar), .conv_busy(cb),
    .soft_reset_pulse(srp), .trim_reload(trl), .alarm_pin_o(pin_o), .alarm_pin_oe(pin_oe),
    .general_out1(gout1), .bias_on(bias_on), .ref_on(ref_on), .irq(irq));
  conv_model m (.clk(clk), .alarm_trip(at), .hyst_release(hr), .alert_read(ar),
    .conv_busy(cb));
  // verdict and end of run
  task test_done();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer; waits for pready under a bound, no latency assumed
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      test_done();
    end
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // event then settle: pin follows two edges after the event
  task ev(input int k, input logic exp);
    m.pulse(k);
    repeat (3) @(posedge clk);
    chk(pin_o, exp);
  endtask
  // hang guard
  initial begin
    #800000;
    error_cnt++;
    test_done();
  end
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    rdc(`OFS_SETTINGS, 32'h00c0);
    apb(1'b1, `OFS_IRQ_MASK, 32'h1);
    m.pulse(0);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    rdc(`OFS_IRQ_STATUS, 32'h1);
    apb(1'b1, `OFS_IRQ_STATUS, 32'h7);
    #1 chk(irq, 1'b0);
    m.pulse(2);
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    // power modes and general output 1 swept together
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `OFS_SETTINGS, 32'h00c0 | i | ((i & 1) << 2));
      repeat (2) @(posedge clk);
      chk({bias_on, ref_on}, i);
      chk(gout1, i & 1);
    end
    apb(1'b1, `OFS_SETTINGS, 32'h00e0);
    rdc(`OFS_SETTINGS, 32'h00c0);
    apb(1'b1, `OFS_SETTINGS, 32'h00f0);
    rdc(`OFS_SETTINGS, 32'h00f0);
    // general output 0 level against drive type
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `OFS_SETTINGS, {24'h0, pin_set[i]});
      repeat (3) @(posedge clk);
      chk({pin_o, pin_oe}, pin_exp[i]);
    end
    apb(1'b1, `OFS_SETTINGS, 32'h00d0);
    repeat (3) @(posedge clk);
    chk(pin_o, 1'b1);
    apb(1'b1, `OFS_SETTINGS, 32'h00d8);
    ev(0, 1'b1);
    ev(1, 1'b1);
    ev(2, 1'b0);
    apb(1'b1, `OFS_SETTINGS, 32'h0058);
    ev(0, 1'b1);
    ev(1, 1'b0);
    apb(1'b1, `OFS_SETTINGS, 32'h00f8);
    m.busy(1'b1);
    repeat (3) @(posedge clk);
    chk(pin_o, 1'b1);
    rdc(`OFS_STATE, 32'h12);
    m.busy(1'b0);
    repeat (3) @(posedge clk);
    chk(pin_o, 1'b0);
    apb(1'b1, `OFS_SETTINGS, 32'h00d8);
    ev(0, 1'b1);
    apb(1'b1, `OFS_SETTINGS, 32'h02d8);
    #1;
    for (int k = 0; k < 5 && srp !== 1'b1; k++) @(posedge clk) #1;
    chk({srp, trl}, 2'h3);
    repeat (3) @(posedge clk);
    chk(pin_o, 1'b0);
    rdc(`OFS_SETTINGS, 32'h00d8);
    rdc(`OFS_IRQ_STATUS, 32'h7);
    rdc(`OFS_IRQ_MASK, 32'h1);
    test_done();
  end
endmodule
